// ### core/fhv_host.sv
// Controller end: sequences the programming voltage and bus accesses
`timescale 1ns/1ps
`include "fhv_consts.svh"
module fhv_host
  import fhv_pkg::*;
#(
  parameter int POWERUP_CYC = `FHV_OSC_SETTLE_MS * 1000 * `FHV_CLK_MHZ, // Oscillator settling
  parameter int SETTLE_CYC = `FHV_READ_SETUP_US * `FHV_CLK_MHZ, // Array read setup
  parameter int WDG_CYC = `FHV_PROG_MAX_US * `FHV_CLK_MHZ // Longest program or erase
) (
  input wire logic clk_i, // System clock, 50 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  fhv_link_if.host link // Bus and pins toward the device
);
  localparam int HOLD = `FHV_RST_HOLD_CYC;
  // Counts below one would leave the sequencer stuck or unsafe
  if (POWERUP_CYC < 1 || SETTLE_CYC < 1 || WDG_CYC < 1) begin : g_bad_counts
    $error("fhv_host: counts must be at least one");
  end

  logic [31:0] cmd_q;
  logic [6:0] ctrl_q;
  logic [31:0] pwr_cnt;
  logic [31:0] settle_cnt;
  logic [31:0] wdg_cnt;
  logic [3:0] rst_cnt;
  logic pwr_done, rst_force_q, vpp_q, pe_q, hv_seen_q, refused_q, ext_seen_q, wdg_exp_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] last_q;
  fhv_host_st_e st_q;
  logic req_q, we_q;
  logic [16:0] addr_q;
  logic [7:0] wdata_q;
  logic reset_active, allow_vpp, cmd_wr, start, refuse, done, wdg_fire;
  logic [16:0] c_addr;
  logic [31:0] c_word;
  logic [31:0] ctrl_word;
  logic [7:0] c_wdata;
  logic c_we, c_win, c_pe;

  // Merges written bytes under their selects
  function automatic logic [31:0] fhv_merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : fhv_merge

  // Wishbone answer one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_adr_i == `FHV_HOST_CMD) begin
        rdat_q <= cmd_q;
      end else if (wb_adr_i == `FHV_HOST_CTRL) begin
        rdat_q <= {25'h0, ctrl_q};
      end else if (wb_adr_i == `FHV_HOST_STAT) begin
        rdat_q <= {17'h0, wdg_exp_q, pwr_done, vpp_q, ext_seen_q, hv_seen_q, refused_q,
                   st_q == HS_WAIT, last_q};
      end else begin
        rdat_q <= 32'h0;
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Command fields as they will stand after this write
  assign cmd_wr = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_adr_i == `FHV_HOST_CMD;
  assign c_word = fhv_merge(cmd_q, wb_dat_i, wb_sel_i);
  assign ctrl_word = fhv_merge({25'h0, ctrl_q}, wb_dat_i, wb_sel_i);
  assign c_addr = c_word[16:0];
  assign c_wdata = c_word[`FHV_CMD_WDATA_LSB +: 8];
  assign c_we = c_word[`FHV_CMD_WE];
  assign c_win = c_addr >= `FHV_ADDR_FMC && c_addr <= `FHV_ADDR_ERASE_BLOCK_SELECT_TWO;
  assign c_pe = c_wdata[`FHV_FMC_P] || c_wdata[`FHV_FMC_E];
  assign refuse = st_q != HS_IDLE || ctrl_q[`FHV_CTRL_STANDBY_REQUEST_PIN] || reset_active
    || (!c_we && c_addr < `FHV_ARRAY_TOP && settle_cnt != 0)
    || (c_we && c_addr == `FHV_ADDR_FMC && c_pe && !ctrl_q[`FHV_CTRL_WDG])
    || (ctrl_q[`FHV_CTRL_MODE_LSB +: 2] == `FHV_MODE_2 && c_win && !hv_seen_q
        && !(!c_we && c_addr == `FHV_ADDR_FMC));
  assign start = cmd_wr && !refuse;
  assign done = st_q == HS_WAIT && link.ack;

  // Host registers written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_q <= 32'h0;
      ctrl_q <= 7'h00;
    end else if (wb_cyc_i && wb_stb_i && ack_q && wb_we_i) begin
      if (wb_adr_i == `FHV_HOST_CMD) begin
        cmd_q <= fhv_merge(cmd_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `FHV_HOST_CTRL) begin
        ctrl_q <= ctrl_word[6:0];
      end
    end
  end

  // Power-up hold of reset through oscillator settling
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_cnt <= 32'h0;
    end else if (!pwr_done) begin
      pwr_cnt <= pwr_cnt + 32'h1;
    end
  end
  assign pwr_done = pwr_cnt >= 32'(POWERUP_CYC);
  assign reset_active = !pwr_done || ctrl_q[`FHV_CTRL_RST] || rst_force_q;

  // Cycles that reset has been held, saturating at the hold count
  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_active) begin
      rst_cnt <= 4'h0;
    end else if (rst_cnt < 4'(HOLD)) begin
      rst_cnt <= rst_cnt + 4'h1;
    end
  end

  // Voltage moves only when safe, then array reads wait out the setup
  assign allow_vpp = pwr_done && !pe_q && st_q == HS_IDLE
    && (!reset_active || rst_cnt == 4'(HOLD));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vpp_q <= 1'b0;
      settle_cnt <= 32'h0;
    end else if (allow_vpp && vpp_q != ctrl_q[`FHV_CTRL_VPP]) begin
      vpp_q <= ctrl_q[`FHV_CTRL_VPP];
      settle_cnt <= 32'(SETTLE_CYC);
    end else if (settle_cnt != 0) begin
      settle_cnt <= settle_cnt - 32'h1;
    end
  end

  // Shadow of program and erase bits, watchdog on them
  assign wdg_fire = pe_q && wdg_cnt >= 32'(WDG_CYC) - 32'h1;
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_active || ctrl_q[`FHV_CTRL_STANDBY_REQUEST_PIN]) begin
      pe_q <= 1'b0;
      wdg_cnt <= 32'h0;
    end else begin
      if (done && we_q && addr_q == `FHV_ADDR_FMC && !link.ext) begin
        pe_q <= wdata_q[`FHV_FMC_P] || wdata_q[`FHV_FMC_E];
      end
      wdg_cnt <= pe_q ? wdg_cnt + 32'h1 : 32'h0;
    end
  end

  // Watchdog expiry forces a reset long enough to clear the bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_force_q <= 1'b0;
      wdg_exp_q <= 1'b0;
    end else begin
      if (wdg_fire) begin
        rst_force_q <= 1'b1;
        wdg_exp_q <= 1'b1;
      end else if (rst_cnt == 4'(HOLD)) begin
        rst_force_q <= 1'b0;
      end
    end
  end

  // Request state machine toward the device
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= HS_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 17'h0;
      wdata_q <= 8'h0;
    end else begin
      case (st_q)
        HS_IDLE: begin
          if (start) begin
            st_q <= HS_WAIT;
            req_q <= 1'b1;
            we_q <= c_we;
            addr_q <= c_addr;
            wdata_q <= c_wdata;
          end
        end
        HS_WAIT: begin
          if (link.ack || reset_active) begin
            st_q <= HS_IDLE;
            req_q <= 1'b0;
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  // Status: refusal, read data and the whole-byte voltage probe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refused_q <= 1'b0;
      hv_seen_q <= 1'b0;
      ext_seen_q <= 1'b0;
      last_q <= 8'h0;
    end else begin
      if (cmd_wr) begin
        refused_q <= refuse;
      end
      if (allow_vpp && vpp_q != ctrl_q[`FHV_CTRL_VPP]) begin
        hv_seen_q <= 1'b0;
      end else if (done && !we_q && addr_q == `FHV_ADDR_FMC) begin
        hv_seen_q <= !link.ext && link.rdata != `FHV_ALL_ONES;
      end
      if (done) begin
        last_q <= link.rdata;
        ext_seen_q <= link.ext;
      end
    end
  end

  // Pins toward the device
  assign link.req = req_q;
  assign link.we = we_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign link.reset_input_pin_n = !reset_active;
  assign link.standby_request_pin_n = !ctrl_q[`FHV_CTRL_STANDBY_REQUEST_PIN];
  assign link.programming_supply_pin = vpp_q && !ctrl_q[`FHV_CTRL_STANDBY_REQUEST_PIN];
  assign link.mode_select_pin_one = ctrl_q[`FHV_CTRL_MODE_LSB + 1];
  assign link.mode_select_pin_zero = ctrl_q[`FHV_CTRL_MODE_LSB];
  assign link.writer_mode = ctrl_q[`FHV_CTRL_WRITER];
endmodule : fhv_host

// ### core/fhv_consts.svh
// Constants for the flash high-voltage register gating block
`ifndef FHV_CONSTS_SVH
`define FHV_CONSTS_SVH
// Byte addresses of the flash control window
`define FHV_ADDR_FMC 17'h0FF80
`define FHV_ADDR_GAP 17'h0FF81
`define FHV_ADDR_ERASE_BLOCK_SELECT_ONE 17'h0FF82
`define FHV_ADDR_ERASE_BLOCK_SELECT_TWO 17'h0FF83
// First address above the 32-kbyte array, last writer-mode address
`define FHV_ARRAY_TOP 17'h08000
`define FHV_WRITER_TOP 17'h1FFFF
// Reset and fixed read values
`define FHV_FMC_RST 8'h80
`define FHV_EBR_RST 8'h00
`define FHV_ALL_ONES 8'hFF
// Control register fields
`define FHV_FMC_VPP 7
`define FHV_FMC_E 1
`define FHV_FMC_P 0
// Mode pin codes
`define FHV_MODE_1 2'h1
`define FHV_MODE_2 2'h2
`define FHV_MODE_3 2'h3
// Timing
`define FHV_CLK_MHZ 50
`define FHV_RST_HOLD_CYC 10
`define FHV_OSC_SETTLE_MS 20
`define FHV_READ_SETUP_US 50
`define FHV_PROG_MAX_US 1000
// Host register offsets and command fields
`define FHV_HOST_CMD 8'h00
`define FHV_HOST_CTRL 8'h04
`define FHV_HOST_STAT 8'h08
`define FHV_CMD_WDATA_LSB 17
`define FHV_CMD_WE 25
`define FHV_CTRL_VPP 0
`define FHV_CTRL_RST 1
`define FHV_CTRL_STANDBY_REQUEST_PIN 2
`define FHV_CTRL_MODE_LSB 3
`define FHV_CTRL_WDG 5
`define FHV_CTRL_WRITER 6
`endif

// ### core/fhv_pkg.sv
// Types shared by both ends of the flash high-voltage link
package fhv_pkg;
  typedef enum logic [2:0] {
    ROUTE_FMC,
    ROUTE_ERASE_BLOCK_SELECT_ONE,
    ROUTE_ERASE_BLOCK_SELECT_TWO,
    ROUTE_ONES,
    ROUTE_ARRAY,
    ROUTE_EXT
  } fhv_route_e;
  typedef enum logic {
    HS_IDLE,
    HS_WAIT
  } fhv_host_st_e;
endpackage : fhv_pkg

// ### core/fhv_link_if.sv
// Link between the flash gating device and its controller
`timescale 1ns/1ps
interface fhv_link_if;
  logic [16:0] addr;
  logic we;
  logic req;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic ext;
  logic reset_input_pin_n;
  logic standby_request_pin_n;
  logic programming_supply_pin;
  logic mode_select_pin_one;
  logic mode_select_pin_zero;
  logic writer_mode;
  modport dev (
    input addr, we, req, wdata, reset_input_pin_n, standby_request_pin_n,
    input programming_supply_pin, mode_select_pin_one, mode_select_pin_zero, writer_mode,
    output rdata, ack, ext
  );
  modport host (
    output addr, we, req, wdata, reset_input_pin_n, standby_request_pin_n,
    output programming_supply_pin, mode_select_pin_one, mode_select_pin_zero, writer_mode,
    input rdata, ack, ext
  );
endinterface : fhv_link_if

// ### core/fhv_device.sv
// Device end: gating and decoding of the flash control registers
`timescale 1ns/1ps
`include "fhv_consts.svh"

// Function
// - Control registers reachable only with high voltage
// - High voltage: mode 1 reads ones, modes 2 and 3 registers
// - No high voltage: modes 1 and 2 external, mode 3 reads ones
// - Voltage flag follows supply pin threshold
// - Flag set allows control register writes
// - Writer mode: above array reads all ones
// - Low standby pin enters hardware standby
// - Host changes voltage in reset only after ten cycles held
// - Host waits oscillator settling before applying voltage
// - Program and erase bits clear during change
// - Watchdog armed before program or erase
// - Voltage changes only when array not read
// - Mode 2 confirms voltage before register access
// - Detect voltage by whole-byte compare with ones
module fhv_device
  import fhv_pkg::*;
(
  input wire logic clk_i, // System clock, 50 MHz
  input wire logic rst_i, // Synchronous reset, active high
  fhv_link_if.dev link, // Bus and pins from the controller
  input wire logic [7:0] arr_rdata_i, // Flash array read data
  output logic arr_rd_o, // Flash array read strobe
  output logic [16:0] arr_addr_o, // Flash array address
  output logic [7:0] flash_mode_control_o, // Control register to the array
  output logic [7:0] erase_block_select_one_o, // Erase block select, low blocks
  output logic [7:0] erase_block_select_two_o, // Erase block select, high blocks
  output logic hv_flag_o, // High voltage seen on the supply pin
  output logic standby_o // Hardware standby in force
);

  // Registered state
  logic hv_q;
  logic [7:0] fmc_q;
  logic [7:0] erase_block_select_one_q;
  logic [7:0] erase_block_select_two_q;
  logic ack_q;
  logic ext_q;
  logic [7:0] rdata_q;

  // Decoded mode and access
  logic [1:0] mode;
  logic standby;
  logic regs_clear;
  logic take;
  fhv_route_e route;
  logic [7:0] fmc_view;

  // Sorts one address into the area it reaches
  function automatic fhv_route_e fhv_route(
    input logic [16:0] a,
    input logic [1:0] md,
    input logic wm,
    input logic hv
  );
    fhv_route_e r;
    r = ROUTE_ONES;
    if (wm) begin
      // Writer mode: only the 32-kbyte array answers
      if (a < `FHV_ARRAY_TOP) begin
        r = ROUTE_ARRAY;
      end else begin
        r = ROUTE_ONES;
      end
    end else if (a >= `FHV_ADDR_FMC && a <= `FHV_ADDR_ERASE_BLOCK_SELECT_TWO) begin
      if (hv) begin
        if (md == `FHV_MODE_1) begin
          r = ROUTE_ONES;
        end else if (md == `FHV_MODE_2 || md == `FHV_MODE_3) begin
          if (a == `FHV_ADDR_FMC) begin
            r = ROUTE_FMC;
          end else if (a == `FHV_ADDR_ERASE_BLOCK_SELECT_ONE) begin
            r = ROUTE_ERASE_BLOCK_SELECT_ONE;
          end else if (a == `FHV_ADDR_ERASE_BLOCK_SELECT_TWO) begin
            r = ROUTE_ERASE_BLOCK_SELECT_TWO;
          end else begin
            r = ROUTE_ONES;
          end
        end else begin
          r = ROUTE_ONES;
        end
      end else begin
        if (md == `FHV_MODE_3) begin
          r = ROUTE_ONES;
        end else if (md == `FHV_MODE_1 || md == `FHV_MODE_2) begin
          r = ROUTE_EXT;
        end else begin
          r = ROUTE_ONES;
        end
      end
    end else if (md == `FHV_MODE_1) begin
      r = ROUTE_EXT;
    end else if (md == `FHV_MODE_2 || md == `FHV_MODE_3) begin
      if (a < `FHV_ARRAY_TOP) begin
        r = ROUTE_ARRAY;
      end else if (md == `FHV_MODE_2) begin
        r = ROUTE_EXT;
      end else begin
        r = ROUTE_ONES;
      end
    end else begin
      // Illegal mode 0: nothing inside answers
      r = ROUTE_ONES;
    end
    return r;
  endfunction : fhv_route

  // Mode pins and standby level
  assign mode = {link.mode_select_pin_one, link.mode_select_pin_zero};
  assign standby = !link.standby_request_pin_n;
  assign standby_o = standby;

  // Registers return to their initial values under any reset or standby
  assign regs_clear = rst_i || !link.reset_input_pin_n || standby;

  // A new request is taken once, and never in standby or reset
  assign take = link.req && !ack_q && !regs_clear;
  assign route = fhv_route(link.addr, mode, link.writer_mode, hv_q);

  // Top bit of the control register shows the voltage flag
  assign fmc_view = {hv_q, fmc_q[`FHV_FMC_VPP-1:0]};

  // Array read strobe is a handshake output, so it is combinational
  assign arr_rd_o = take && !link.we && route == ROUTE_ARRAY;
  assign arr_addr_o = link.addr;

  // Voltage flag follows the threshold comparator on the supply pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hv_q <= 1'b0;
    end else begin
      hv_q <= link.programming_supply_pin;
    end
  end

  // Flash mode control register: bits below the flag are writable
  always_ff @(posedge clk_i) begin
    if (regs_clear) begin
      fmc_q <= `FHV_FMC_RST;
    end else if (take && link.we && route == ROUTE_FMC) begin
      fmc_q <= {1'b1, link.wdata[`FHV_FMC_VPP-1:0]};
    end
  end

  // Erase block select registers
  always_ff @(posedge clk_i) begin
    if (regs_clear) begin
      erase_block_select_one_q <= `FHV_EBR_RST;
      erase_block_select_two_q <= `FHV_EBR_RST;
    end else if (take && link.we) begin
      if (route == ROUTE_ERASE_BLOCK_SELECT_ONE) begin
        erase_block_select_one_q <= link.wdata;
      end
      if (route == ROUTE_ERASE_BLOCK_SELECT_TWO) begin
        erase_block_select_two_q <= link.wdata;
      end
    end
  end

  // Answer one cycle after the request is taken
  always_ff @(posedge clk_i) begin
    if (regs_clear) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  // Read data and external flag for the answer
  always_ff @(posedge clk_i) begin
    if (regs_clear) begin
      rdata_q <= `FHV_ALL_ONES;
      ext_q <= 1'b0;
    end else if (take) begin
      ext_q <= route == ROUTE_EXT;
      case (route)
        ROUTE_FMC: rdata_q <= fmc_view;
        ROUTE_ERASE_BLOCK_SELECT_ONE: rdata_q <= erase_block_select_one_q;
        ROUTE_ERASE_BLOCK_SELECT_TWO: rdata_q <= erase_block_select_two_q;
        ROUTE_ARRAY: rdata_q <= link.we ? `FHV_ALL_ONES : arr_rdata_i;
        ROUTE_EXT: rdata_q <= `FHV_ALL_ONES;
        default: rdata_q <= `FHV_ALL_ONES;
      endcase
    end
  end

  // Link answers
  assign link.ack = ack_q;
  assign link.rdata = rdata_q;
  assign link.ext = ext_q;

  // Array side sees the stored registers and the flag
  assign flash_mode_control_o = fmc_view;
  assign erase_block_select_one_o = erase_block_select_one_q;
  assign erase_block_select_two_o = erase_block_select_two_q;
  assign hv_flag_o = hv_q;

endmodule : fhv_device

// ### tb/fhv_link_props.sv
// Concurrent checks on the link between controller and device
`timescale 1ns/1ps
module fhv_link_props #(
  parameter int POWERUP_CYC = 50 // Power-up reset hold
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [16:0] addr, // Link address
  input wire logic we, // Link write
  input wire logic req, // Link request
  input wire logic [7:0] wdata, // Link write data
  input wire logic [7:0] rdata, // Link read data
  input wire logic ack, // Link answer
  input wire logic ext, // Access went external
  input wire logic reset_input_pin_n, // Reset pin
  input wire logic standby_request_pin_n, // Standby pin
  input wire logic programming_supply_pin, // High voltage present
  input wire logic mode_select_pin_one, // Mode high bit
  input wire logic mode_select_pin_zero // Mode low bit
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] md;
  logic win;
  logic [7:0] hold_q;
  logic [15:0] up_q;
  logic [1:0] pe_q;
  // Mode code and control window decode
  assign md = {mode_select_pin_one, mode_select_pin_zero};
  assign win = (addr >= 17'h0FF80) && (addr <= 17'h0FF83);
  // Cycles the reset pin has been held low
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_input_pin_n) hold_q <= 8'h00;
    else if (hold_q != 8'hFF) hold_q <= hold_q + 8'h01;
  end
  // Cycles since reset release, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i) up_q <= 16'h0000;
    else if (up_q != 16'hFFFF) up_q <= up_q + 16'h0001;
  end
  // Program and erase bits last written over the link
  always_ff @(posedge clk_i) begin
    if (rst_i || !reset_input_pin_n) pe_q <= 2'h0;
    else if (ack && we && addr == 17'h0FF80) pe_q <= wdata[1:0];
  end
  chk_ack_one_cycle: assert property (
    req && !ack && reset_input_pin_n && standby_request_pin_n |=> ack ##1 !ack)
    else $error("link request not answered in one cycle");
  chk_hv_mode1_ones: assert property (
    ack && !we && win && programming_supply_pin && md == 2'h1 |-> rdata == 8'hFF && !ext)
    else $error("mode 1 window read not all ones");
  chk_fmc_flag_read: assert property (
    ack && !we && addr == 17'h0FF80 && programming_supply_pin && md[1] |-> rdata[7] && !ext)
    else $error("control register read wrong");
  chk_nohv_ext_route: assert property (
    ack && win && !programming_supply_pin && md != 2'h3 |-> ext)
    else $error("window access not routed external");
  chk_nohv_mode3_ones: assert property (
    ack && !we && win && !programming_supply_pin && md == 2'h3 |-> rdata == 8'hFF && !ext)
    else $error("mode 3 window read not all ones");
  chk_vpp_after_hold: assert property (
    $changed(programming_supply_pin) && !reset_input_pin_n |-> hold_q >= 8'h0A)
    else $error("voltage changed too early in reset");
  chk_powerup_vpp: assert property (
    $changed(programming_supply_pin) |-> int'(up_q) >= POWERUP_CYC)
    else $error("voltage changed before power-up hold");
  chk_pe_clear_change: assert property (
    $changed(programming_supply_pin) |-> pe_q == 2'h0)
    else $error("voltage changed with program or erase set");
  chk_no_array_settle: assert property (
    $changed(programming_supply_pin) |-> (!(req && addr < 17'h08000)) [*4])
    else $error("array read while voltage settling");
  chk_mode2_gate: assert property (
    req && !programming_supply_pin && md == 2'h2 && win |-> !we && addr == 17'h0FF80)
    else $error("mode 2 window access without voltage check");
  chk_standby_silent: assert property (
    !standby_request_pin_n ##1 !standby_request_pin_n |-> !ack)
    else $error("answer given in standby");
endmodule : fhv_link_props

// ### tb/flash_hv_register_gating_tb_top.sv
// Self-checking bench for the flash high-voltage gating link
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module flash_hv_register_gating_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, wwe = 1'b0;
  logic [7:0] adr = 8'h00, arr_v = 8'h5A, fmc_m, eb1_m, eb2_m;
  logic [31:0] dat = 32'h0, rd, wb_dat_o;
  logic wb_ack_o, hv_flag, standby_request_pin;
  int err_total = 0, checks = 0;
  fhv_link_if link_bus ();
  // Free-running 50 MHz clock
  always #10 clk_i = ~clk_i;
  fhv_host #(.POWERUP_CYC(50), .SETTLE_CYC(8), .WDG_CYC(40)) fhv_host_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .link(link_bus.host));
  fhv_device fhv_device_inst (
    .clk_i(clk_i), .rst_i(rst_i), .link(link_bus.dev), .arr_rdata_i(arr_v), .arr_rd_o(),
    .arr_addr_o(), .flash_mode_control_o(), .erase_block_select_one_o(),
    .erase_block_select_two_o(), .hv_flag_o(hv_flag), .standby_o(standby_request_pin));
  fhv_link_props #(.POWERUP_CYC(50)) fhv_link_props_inst (
    .clk_i(clk_i), .rst_i(rst_i), .addr(link_bus.addr), .we(link_bus.we),
    .req(link_bus.req), .wdata(link_bus.wdata), .rdata(link_bus.rdata), .ack(link_bus.ack),
    .ext(link_bus.ext), .reset_input_pin_n(link_bus.reset_input_pin_n),
    .standby_request_pin_n(link_bus.standby_request_pin_n),
    .programming_supply_pin(link_bus.programming_supply_pin),
    .mode_select_pin_one(link_bus.mode_select_pin_one),
    .mode_select_pin_zero(link_bus.mode_select_pin_zero));
  // Prints the counts and the verdict, then ends the run
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Reads status until the chosen bit shows the wanted value
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      wb(1'b0, 8'h08, 32'h0);
      n++;
    end while (rd[b] !== v && n < 60);
    if (rd[b] !== v) begin
      err_total++;
      $display("unexpected poll bit %0d exp %0h got %0h", b, v, rd[b]);
    end
  endtask : poll
  // Sets voltage, mode and flags {watchdog, standby, hold reset}, then lets it settle
  task automatic ctrl(input logic v, input logic [1:0] m, input logic [2:0] f);
    wb(1'b1, 8'h04, {26'h0, f[2], m, f[1:0], v});
    poll(12, v);
    repeat (12) @(posedge clk_i);
  endtask : ctrl
  // Expected {refused, ext, data} of one link access
  function automatic logic [9:0] exp_rd(logic [1:0] m, logic hv, logic w, logic [16:0] a);
    logic win;
    win = a >= 17'h0FF80 && a <= 17'h0FF83;
    if (win && m == 2'h2 && !hv && (w || a != 17'h0FF80)) return {2'b10, 8'hFF};
    if (win && hv && m != 2'h1) begin
      case (a[1:0])
        2'h0: return {3'b001, fmc_m[6:0]};
        2'h2: return {2'b00, eb1_m};
        2'h3: return {2'b00, eb2_m};
        default: return {2'b00, 8'hFF};
      endcase
    end
    if (win) return {1'b0, !hv && m != 2'h3, 8'hFF};
    if (a < 17'h08000 && m != 2'h1) return {2'b00, arr_v};
    return {1'b0, m != 2'h3, 8'hFF};
  endfunction : exp_rd
  // One link access through the command register, checked against the model
  task automatic probe(input logic [1:0] m, input logic hv, input logic w,
                       input logic [16:0] a, input logic [7:0] d);
    logic [9:0] e;
    e = exp_rd(m, hv, w, a);
    wb(1'b1, 8'h00, {6'h00, w, d, a});
    poll(8, 1'b0);
    `CHK("refused", e[9], rd[9])
    if (!e[9]) `CHK("ext", e[8], rd[11])
    if (!e[9] && !e[8] && !w) `CHK("rdata", e[7:0], rd[7:0])
    if (!e[9] && w && hv && m != 2'h1 && a[16:2] == 15'h3FE0) begin
      if (a[1:0] == 2'h0) fmc_m = d;
      if (a[1:0] == 2'h2) eb1_m = d;
      if (a[1:0] == 2'h3) eb2_m = d;
    end
  endtask : probe
  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    close_out();
  end
  // Main sequence
  initial begin
    logic [1:0] m;
    void'($urandom(16014));
    fmc_m = 8'h80;
    eb1_m = 8'h00;
    eb2_m = 8'h00;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h08, 32'h0);
    `CHK("powerup_early", 1'b0, rd[13])
    wb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    poll(13, 1'b1);
    for (int v = 1; v >= 0; v--) begin
      for (int k = 1; k <= 3; k++) begin
        m = 2'(k);
        arr_v <= 8'($urandom);
        ctrl(1'(v), m, 3'h0);
        `CHK("hv_flag", 1'(v), hv_flag)
        probe(m, 1'(v), 1'b0, 17'h0FF80, 8'h00);
        probe(m, 1'(v), 1'b1, 17'h0FF80, 8'($urandom) & 8'h7C);
        probe(m, 1'(v), 1'b1, 17'h0FF82, 8'($urandom));
        probe(m, 1'(v), 1'b1, 17'h0FF83, 8'($urandom));
        for (int j = 0; j < 4; j++) probe(m, 1'(v), 1'b0, 17'h0FF80 + 17'(j), 8'h00);
        probe(m, 1'(v), 1'b0, 17'($urandom % 32768), 8'h00);
        probe(m, 1'(v), 1'b0, 17'h08000 + 17'($urandom % 32512), 8'h00);
        $display("test mode %0d vpp %0d done", k, v);
      end
    end
    ctrl(1'b1, 2'h3, 3'h0);
    wb(1'b1, 8'h00, {6'h00, 1'b1, 8'h01, 17'h0FF80});
    poll(8, 1'b0);
    `CHK("pe_unarmed", 1'b1, rd[9])
    ctrl(1'b0, 2'h3, 3'h1);
    ctrl(1'b1, 2'h3, 3'h0);
    fmc_m = 8'h80;
    eb1_m = 8'h00;
    eb2_m = 8'h00;
    probe(2'h3, 1'b1, 1'b0, 17'h0FF80, 8'h00);
    probe(2'h3, 1'b1, 1'b0, 17'h0FF82, 8'h00);
    $display("test reset hold done");
    ctrl(1'b1, 2'h3, 3'h4);
    probe(2'h3, 1'b1, 1'b1, 17'h0FF80, 8'h01);
    poll(14, 1'b1);
    `CHK("wdg_expired", 1'b1, rd[14])
    repeat (16) @(posedge clk_i);
    fmc_m = 8'h80;
    probe(2'h3, 1'b1, 1'b0, 17'h0FF80, 8'h00);
    wb(1'b1, 8'h04, 32'h59);
    repeat (4) @(posedge clk_i);
    wb(1'b1, 8'h00, {6'h00, 1'b0, 8'h00, 17'h0FF80});
    poll(8, 1'b0);
    `CHK("writer_window", 10'h0FF, {rd[9], rd[11], rd[7:0]})
    wb(1'b1, 8'h04, 32'h18);
    poll(12, 1'b0);
    wb(1'b1, 8'h00, {6'h00, 1'b0, 8'h00, 17'h00100});
    poll(8, 1'b0);
    `CHK("settle_refused", 1'b1, rd[9])
    $display("test watchdog writer settle done");
    ctrl(1'b0, 2'h3, 3'h2);
    `CHK("standby_on", 1'b1, standby_request_pin)
    wb(1'b1, 8'h00, {6'h00, 1'b0, 8'h00, 17'h0FF80});
    poll(8, 1'b0);
    `CHK("standby_refused", 1'b1, rd[9])
    ctrl(1'b0, 2'h3, 3'h0);
    `CHK("standby_off", 1'b0, standby_request_pin)
    $display("test standby done");
    close_out();
  end
endmodule : flash_hv_register_gating_tb_top
